// ===== design/iit_pkg.sv
package iit_pkg;

  // ****************************************************************
  // Widths and timing constants
  // ****************************************************************
  localparam int unsigned REG_W   = 4;
  localparam int unsigned CNT_W   = 4;
  localparam int unsigned NREG    = 16;
  localparam logic [3:0]  PC_REG  = 4'hf;
  localparam logic [3:0]  LR_REG  = 4'he;
  localparam logic [3:0]  LAT_ALU = 4'h1;
  localparam logic [3:0]  LAT_LD  = 4'h3;
  localparam logic [3:0]  LAT_RSH = 4'h2;
  localparam logic [3:0]  FAIL_CAP = 4'h5;
  localparam logic [3:0]  FAIL_FLOOR = 4'h3;
  localparam logic [3:0]  RET_OK  = 4'h4;
  localparam logic [3:0]  RET_BAD = 4'h7;
  localparam logic [3:0]  MOV_PC_N = 4'h5;
  localparam logic [3:0]  MOV_PC_I = 4'h6;
  localparam logic [3:0]  MOV_PC_R = 4'h7;
  localparam logic [3:0]  ALU_PC_N = 4'h7;
  localparam logic [3:0]  ALU_PC_R = 4'h8;
  localparam logic [3:0]  ONE     = 4'h1;
  localparam logic [3:0]  TWO     = 4'h2;
  localparam logic [3:0]  AL_COND = 4'he;

  // ****************************************************************
  // Operation classes
  // ****************************************************************
  typedef enum logic [2:0] {
    OP_ALU   = 3'h0,
    OP_LOAD  = 3'h1,
    OP_STORE = 3'h2,
    OP_MOV   = 3'h3,
    OP_MULTI = 3'h4
  } iit_op_type;

  typedef enum logic [1:0] {
    SH_NONE = 2'h0,
    SH_IMM  = 2'h1,
    SH_REG  = 2'h2
  } iit_shift_type;

  // Decoded instruction presented by decode.
  typedef struct packed {
    iit_op_type    op;
    iit_shift_type shift;
    logic [3:0]    cond;
    logic          cond_pass;
    logic          sets_flags;
    logic          wr_en;
    logic [3:0]    rd;
    logic [3:0]    rn;
    logic          rn_en;
    logic [3:0]    rm;
    logic          rm_en;
    logic [3:0]    rs;
    logic [3:0]    multi_cycles;
    logic          ret_hit;
  } iit_instr_type;

  // Per-register scoreboard entry.
  typedef struct packed {
    logic       busy;
    logic [3:0] ready_in;
    logic [3:0] cond;
  } iit_sb_type;

endpackage : iit_pkg

// ===== design/iit_flag_gap.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// Flag gap counter
// ****************************************************************
module iit_flag_gap (
  // Clock and reset.
  input  wire logic                    core_clk_i,
  input  wire logic                    rst_i,
  // Pipeline events.
  input  wire logic                    cycle_i,
  input  wire logic                    flag_set_i,
  // Gap output.
  output logic [iit_pkg::CNT_W-1:0]    flag_gap_cycles_o
);
  logic [iit_pkg::CNT_W-1:0] gap;
  logic [iit_pkg::CNT_W-1:0] next_gap;

  // Counts every cycle, stalls included, saturating; zero right after a setter.
  always_comb begin
    next_gap = gap;
    if (flag_set_i) begin
      next_gap = '0;
    end else if (cycle_i && gap != '1) begin
      next_gap = gap + 1'b1;
    end
  end

  // Registers the gap.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      gap <= '1;
    end else begin
      gap <= next_gap;
    end
  end

  assign flag_gap_cycles_o = gap;

  a_gap_reset: assert property (@(posedge core_clk_i) disable iff (rst_i)
    flag_set_i |=> gap == '0) else $error("Flag gap not cleared.");
endmodule : iit_flag_gap
`default_nettype wire

// ===== design/iit_cycle_calc.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// Occupancy cycle calculator
// ****************************************************************
module iit_cycle_calc (
  // Instruction and context.
  input  wire iit_pkg::iit_instr_type  instr_i,
  input  wire logic [3:0]              flag_gap_i,
  // Result.
  output logic [3:0]                   cycles_o
);
  logic [3:0] base;
  logic [3:0] upper;
  logic [3:0] lower;
  logic [3:0] floor_v;
  logic [3:0] fail_v;
  logic       is_pc;

  // Picks base, PC bounds and condition-fail adjustment.
  always_comb begin
    is_pc   = instr_i.wr_en && instr_i.rd == iit_pkg::PC_REG;
    base    = (instr_i.shift == iit_pkg::SH_REG) ? iit_pkg::TWO : iit_pkg::ONE;
    upper   = base;
    lower   = base;
    floor_v = iit_pkg::FAIL_FLOOR;
    fail_v  = iit_pkg::FAIL_FLOOR;
    if (instr_i.op == iit_pkg::OP_MOV && is_pc) begin
      if (instr_i.shift == iit_pkg::SH_NONE && instr_i.rm == iit_pkg::LR_REG
          && instr_i.cond == iit_pkg::AL_COND) begin
        lower = instr_i.ret_hit ? iit_pkg::RET_OK : iit_pkg::RET_BAD;
      end else if (instr_i.shift == iit_pkg::SH_NONE) begin
        lower = iit_pkg::MOV_PC_N;
      end else if (instr_i.shift == iit_pkg::SH_IMM) begin
        lower = iit_pkg::MOV_PC_I;
      end else begin
        lower = iit_pkg::MOV_PC_R;
      end
      upper = iit_pkg::MOV_PC_R;
    end else if (instr_i.op == iit_pkg::OP_ALU && is_pc) begin
      lower = (instr_i.shift == iit_pkg::SH_REG) ? iit_pkg::ALU_PC_R : iit_pkg::ALU_PC_N;
      upper = lower;
    end
    if (instr_i.op == iit_pkg::OP_MULTI) begin
      lower = instr_i.multi_cycles;
      upper = lower;
    end
    if (!instr_i.cond_pass) begin
      if (instr_i.op == iit_pkg::OP_MULTI && lower > iit_pkg::TWO) begin
        if (flag_gap_i < iit_pkg::TWO) begin
          floor_v = iit_pkg::FAIL_CAP - flag_gap_i;
        end
        fail_v = (floor_v < lower) ? floor_v : lower;
        cycles_o = fail_v;
      end else if (instr_i.op == iit_pkg::OP_MULTI) begin
        cycles_o = lower;
      end else begin
        cycles_o = base;
      end
    end else if (instr_i.cond != iit_pkg::AL_COND && is_pc
                 && instr_i.op != iit_pkg::OP_MULTI) begin
      if (upper > flag_gap_i && upper - flag_gap_i > lower) begin
        cycles_o = upper - flag_gap_i;
      end else begin
        cycles_o = lower;
      end
    end else begin
      cycles_o = lower;
    end
  end
endmodule : iit_cycle_calc
`default_nettype wire

// ===== design/iit_issue_interlock.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// Issue and interlock timing
// ****************************************************************
module iit_issue_interlock (
  // Clock and reset.
  input  wire logic                    core_clk_i,
  input  wire logic                    rst_i,
  // Decode side.
  input  wire logic                    instr_valid_i,
  input  wire iit_pkg::iit_instr_type  instr_i,
  output logic                         instr_ready_o,
  // Execute side.
  output logic                         issue_o,
  output logic                         stall_o,
  output logic [3:0]                   occupy_cycles_o,
  output logic [3:0]                   flag_gap_cycles_o
);
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_STALL = 3'b010,
    ST_BUSY  = 3'b100
  } iit_state_type;

  iit_state_type              state;
  iit_state_type              next_state;
  iit_pkg::iit_sb_type [15:0] sb;
  iit_pkg::iit_sb_type [15:0] next_sb;
  logic [3:0]                 busy_cnt;
  logic [3:0]                 next_busy_cnt;
  logic [3:0]                 occ;
  logic [3:0]                 next_occ;
  logic [3:0]                 calc_cycles;
  logic [3:0]                 stall_need;
  logic                       issue_now;

  // ****************************************************************
  // Decode helpers
  // ****************************************************************
  // Two condition codes are opposite when they differ only in the low bit and neither is AL_COND.
  function automatic logic opp_cond(input logic [3:0] a, input logic [3:0] b);
    opp_cond = (a[3:1] == b[3:1]) && (a[0] != b[0]) && (a != iit_pkg::AL_COND)
               && (b != iit_pkg::AL_COND);
  endfunction : opp_cond

  // Cycles still needed before a register is usable, with early/late adjust.
  function automatic logic [3:0] need(input iit_pkg::iit_sb_type e,
                                      input logic early, input logic late);
    logic [4:0] v;
    v = {1'b0, e.ready_in};
    if (early) begin
      v = v + 5'h01;
    end
    if (late && v != 5'h00) begin
      v = v - 5'h01;
    end
    need = (e.busy && v > 5'h01) ? v[3:0] - iit_pkg::ONE : 4'h0;
  endfunction : need

  // ****************************************************************
  // Submodules
  // ****************************************************************
  iit_flag_gap u_gap (
    .core_clk_i        (core_clk_i),
    .rst_i             (rst_i),
    .cycle_i           (1'b1),
    .flag_set_i        (issue_now && instr_i.sets_flags && instr_i.cond_pass),
    .flag_gap_cycles_o (flag_gap_cycles_o)
  );

  iit_cycle_calc u_calc (
    .instr_i    (instr_i),
    .flag_gap_i (flag_gap_cycles_o),
    .cycles_o   (calc_cycles)
  );

  // ****************************************************************
  // Hazard evaluation
  // ****************************************************************
  // Worst stall over all operands of the incoming instruction.
  always_comb begin
    logic [3:0] s;
    logic       st;
    s  = 4'h0;
    st = instr_i.op == iit_pkg::OP_STORE;
    // Base of a load or store is early; with a register shift this source is late.
    if (instr_i.rn_en) begin
      if (!(st && instr_i.rn == instr_i.rd && opp_cond(sb[instr_i.rn].cond, instr_i.cond)))
        begin
        if (need(sb[instr_i.rn],
                 instr_i.op == iit_pkg::OP_LOAD || instr_i.op == iit_pkg::OP_STORE,
                 instr_i.shift == iit_pkg::SH_REG) > s) begin
          s = need(sb[instr_i.rn],
                   instr_i.op == iit_pkg::OP_LOAD || instr_i.op == iit_pkg::OP_STORE,
                   instr_i.shift == iit_pkg::SH_REG);
        end
      end
    end
    if (instr_i.rm_en && !(st && instr_i.rm == instr_i.rd
                           && opp_cond(sb[instr_i.rm].cond, instr_i.cond))) begin
      // Only an immediate shift reads this source in the shifter stage.
      if (need(sb[instr_i.rm], instr_i.shift == iit_pkg::SH_IMM, 1'b0) > s) begin
        s = need(sb[instr_i.rm], instr_i.shift == iit_pkg::SH_IMM, 1'b0);
      end
    end
    if (instr_i.shift == iit_pkg::SH_REG && need(sb[instr_i.rs], 1'b1, 1'b0) > s) begin
      s = need(sb[instr_i.rs], 1'b1, 1'b0);
    end
    // Ordering of two writers, relaxed for opposite conditions.
    if (instr_i.wr_en && instr_i.op != iit_pkg::OP_STORE
        && !opp_cond(sb[instr_i.rd].cond, instr_i.cond)) begin
      if (need(sb[instr_i.rd], 1'b0, 1'b1) > s) begin
        s = need(sb[instr_i.rd], 1'b0, 1'b1);
      end
    end
    stall_need = s;
  end

  assign issue_now     = instr_valid_i && state != ST_BUSY && stall_need == 4'h0;
  assign instr_ready_o = issue_now;

  // ****************************************************************
  // Scoreboard
  // ****************************************************************
  // Ages every entry by one cycle and books the issuing writer.
  always_comb begin
    next_sb = sb;
    for (int i = 0; i < iit_pkg::NREG; i++) begin
      if (sb[i].ready_in > 4'h1) begin
        next_sb[i].ready_in = sb[i].ready_in - 4'h1;
      end else begin
        next_sb[i].busy = 1'b0;
      end
    end
    if (issue_now && instr_i.wr_en && instr_i.cond_pass
        && instr_i.op != iit_pkg::OP_STORE) begin
      next_sb[instr_i.rd].busy = 1'b1;
      next_sb[instr_i.rd].cond = instr_i.cond;
      if (instr_i.op == iit_pkg::OP_LOAD) begin
        next_sb[instr_i.rd].ready_in = iit_pkg::LAT_LD;
      end else if (instr_i.shift == iit_pkg::SH_REG) begin
        next_sb[instr_i.rd].ready_in = iit_pkg::LAT_RSH;
      end else begin
        next_sb[instr_i.rd].ready_in = iit_pkg::LAT_ALU;
      end
    end
  end

  // Registers the scoreboard.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sb <= '0;
    end else begin
      sb <= next_sb;
    end
  end

  // ****************************************************************
  // Issue state machine
  // ****************************************************************
  // Holds the issue slot for the instruction's occupancy.
  always_comb begin
    next_state    = state;
    next_busy_cnt = busy_cnt;
    next_occ      = occ;
    case (state)
      // A hazard is re-evaluated every cycle, so a stall lasts exactly as long as needed.
      ST_IDLE, ST_STALL: begin
        next_state = ST_IDLE;
        if (instr_valid_i && stall_need != 4'h0) begin
          next_state = ST_STALL;
        end else if (issue_now) begin
          next_occ = calc_cycles;
          if (calc_cycles > iit_pkg::ONE) begin
            next_busy_cnt = calc_cycles - iit_pkg::ONE;
            next_state    = ST_BUSY;
          end
        end
      end
      ST_BUSY: begin
        next_busy_cnt = busy_cnt - 4'h1;
        if (busy_cnt == 4'h1) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // Registers the state machine.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state    <= ST_IDLE;
      busy_cnt <= 4'h0;
      occ      <= 4'h0;
    end else begin
      state    <= next_state;
      busy_cnt <= next_busy_cnt;
      occ      <= next_occ;
    end
  end

  assign issue_o         = issue_now;
  assign stall_o         = state == ST_BUSY || (instr_valid_i && !issue_now);
  assign occupy_cycles_o = occ;

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_load_latency: assert property (@(posedge core_clk_i) disable iff (rst_i)
    issue_now && instr_i.op == iit_pkg::OP_LOAD && instr_i.wr_en && instr_i.cond_pass
    |=> sb[$past(instr_i.rd)].ready_in == iit_pkg::LAT_LD)
    else $error("Load latency not booked.");
  a_alu_latency: assert property (@(posedge core_clk_i) disable iff (rst_i)
    issue_now && instr_i.op == iit_pkg::OP_ALU && instr_i.shift == iit_pkg::SH_NONE
    && instr_i.wr_en && instr_i.cond_pass && instr_i.rd != iit_pkg::PC_REG
    |=> sb[$past(instr_i.rd)].ready_in == iit_pkg::LAT_ALU)
    else $error("ALU latency not booked.");
  a_busy_length: assert property (@(posedge core_clk_i) disable iff (rst_i)
    issue_now && calc_cycles == 4'h2 |=> state == ST_BUSY ##1 state == ST_IDLE)
    else $error("Two-cycle occupancy wrong.");
  a_fail_bound: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !instr_i.cond_pass && instr_i.op == iit_pkg::OP_MULTI
    |-> calc_cycles <= iit_pkg::FAIL_CAP)
    else $error("Failing multi-cycle count too large.");
  a_stall_blocks: assert property (@(posedge core_clk_i) disable iff (rst_i)
    stall_need != 4'h0 |-> !issue_o)
    else $error("Issued despite stall.");
  a_stall_bound: assert property (@(posedge core_clk_i) disable iff (rst_i)
    instr_valid_i && stall_need != 4'h0 |-> ##[1:16] issue_o)
    else $error("Stalled instruction never issued.");
  a_ret_hit: assert property (@(posedge core_clk_i) disable iff (rst_i)
    instr_i.op == iit_pkg::OP_MOV && instr_i.wr_en && instr_i.rd == iit_pkg::PC_REG
    && instr_i.rm == iit_pkg::LR_REG && instr_i.shift == iit_pkg::SH_NONE
    && instr_i.cond == iit_pkg::AL_COND && instr_i.cond_pass && instr_i.ret_hit
    |-> calc_cycles == iit_pkg::RET_OK)
    else $error("Predicted return count wrong.");
  a_alu_pc: assert property (@(posedge core_clk_i) disable iff (rst_i)
    instr_i.op == iit_pkg::OP_ALU && instr_i.wr_en && instr_i.rd == iit_pkg::PC_REG
    && instr_i.cond == iit_pkg::AL_COND && instr_i.cond_pass
    |-> calc_cycles == ((instr_i.shift == iit_pkg::SH_REG) ? 4'h8 : 4'h7))
    else $error("ALU to PC count wrong.");
  a_pc_fail: assert property (@(posedge core_clk_i) disable iff (rst_i)
    instr_i.op != iit_pkg::OP_MULTI && !instr_i.cond_pass
    |-> calc_cycles == ((instr_i.shift == iit_pkg::SH_REG) ? 4'h2 : 4'h1))
    else $error("Failing PC write count wrong.");
endmodule : iit_issue_interlock
`default_nettype wire

// ===== test/iit_decode_model.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// Decode stage model
// ****************************************************************
module iit_decode_model (
  // Clock and reset.
  input  wire logic              core_clk_i,
  input  wire logic              rst_i,
  // Issue handshake.
  input  wire logic              issue_i,
  output logic                   instr_valid_o,
  output iit_pkg::iit_instr_type instr_o
);
  iit_pkg::iit_instr_type fifo_q[$];
  int                     idle_gap;
  int                     idle_left;
  logic                   taken;

  // Queues one decoded instruction for offer.
  task automatic push(input iit_pkg::iit_instr_type ins);
    fifo_q.push_back(ins);
  endtask : push

  // Starts idle with nothing offered.
  initial begin
    instr_valid_o = 1'b0;
    instr_o = '0;
    idle_gap = 0;
    idle_left = 0;
    taken = 1'b0;
  end

  // Notes whether the offered instruction was taken at this edge.
  always @(posedge core_clk_i) begin
    taken = instr_valid_o && issue_i && !rst_i;
  end

  // Holds the head until taken; between offers the bus shows a changing pattern.
  always @(negedge core_clk_i) begin
    if (taken) begin
      void'(fifo_q.pop_front());
      idle_left = idle_gap;
      taken = 1'b0;
    end
    if (fifo_q.size() != 0 && idle_left == 0 && !rst_i) begin
      instr_valid_o = 1'b1;
      instr_o = fifo_q[0];
    end else begin
      if (idle_left > 0) begin
        idle_left--;
      end
      instr_valid_o = 1'b0;
      instr_o = ~instr_o;
    end
  end
endmodule : iit_decode_model
`default_nettype wire

// ===== test/issue_interlock_timing_tb.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// Issue and interlock timing bench
// ****************************************************************
module issue_interlock_timing_tb;
  logic                   core_clk_i;
  logic                   rst_i;
  logic                   instr_valid;
  iit_pkg::iit_instr_type instr;
  logic                   issue;
  logic                   stall;
  logic [3:0]             occupy_cycles;
  logic [3:0]             flag_gap_cycles;
  int                     mismatches;
  int                     checks_done;
  int                     cyc;
  int                     t_q[$];
  logic [3:0]             o_q[$];
  logic                   pend;
  logic                   ready;
  int                     stl_n;
  int                     rdy_n;

  // Design under test and its decode partner.
  iit_issue_interlock u_iit_issue_interlock (
    .core_clk_i       (core_clk_i),
    .rst_i            (rst_i),
    .instr_valid_i    (instr_valid),
    .instr_i          (instr),
    .instr_ready_o    (ready),
    .issue_o          (issue),
    .stall_o          (stall),
    .occupy_cycles_o  (occupy_cycles),
    .flag_gap_cycles_o(flag_gap_cycles)
  );
  iit_decode_model u_iit_decode_model (
    .core_clk_i   (core_clk_i),
    .rst_i        (rst_i),
    .issue_i      (issue),
    .instr_valid_o(instr_valid),
    .instr_o      (instr)
  );

  // Clock generator.
  always #2.5 core_clk_i = ~core_clk_i;

  // Records issue cycles and cuts a hang short.
  always @(posedge core_clk_i) begin
    cyc = cyc + 1;
    if (!rst_i && instr_valid && issue) begin
      t_q.push_back(cyc);
      pend = 1'b1;
    end
    if (!rst_i && stall) begin
      stl_n++;
    end
    if (!rst_i && ready) begin
      rdy_n++;
    end
    if (cyc >= 3000) begin
      mismatches++;
      end_of_test();
    end
  end

  // Samples the registered occupancy once it has settled.
  always @(negedge core_clk_i) begin
    if (pend) begin
      o_q.push_back(occupy_cycles);
      pend = 1'b0;
    end
  end

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic iit_pkg::iit_instr_type mk(input iit_pkg::iit_op_type op,
      input iit_pkg::iit_shift_type sh, input logic [3:0] rd, input logic [3:0] rn,
      input logic [3:0] rm, input logic [3:0] rs);
    iit_pkg::iit_instr_type x;
    x = '0;
    x.op = op;
    x.shift = sh;
    x.cond = iit_pkg::AL_COND;
    x.cond_pass = 1'b1;
    x.wr_en = (op != iit_pkg::OP_STORE);
    x.rd = rd;
    x.rn = rn;
    x.rn_en = (rn != 4'h0);
    x.rm = rm;
    x.rm_en = (rm != 4'h0);
    x.rs = rs;
    return x;
  endfunction : mk

  // Gives an instruction a condition code and its outcome.
  function automatic iit_pkg::iit_instr_type cnd(input iit_pkg::iit_instr_type x,
      input logic [3:0] c, input logic p);
    x.cond = c;
    x.cond_pass = p;
    return x;
  endfunction : cnd

  // Compares one value and reports a difference.
  task automatic check(input logic [3:0] got, input logic [3:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s got %0d expected %0d", $time, what, got, exp);
    end
  endtask : check

  // Offers two instructions and judges their spacing and occupancies.
  task automatic pair(input iit_pkg::iit_instr_type a, input iit_pkg::iit_instr_type b,
      input logic [3:0] gap, input logic [3:0] occ_a, input logic [3:0] occ_b);
    int n;
    int es;
    t_q.delete();
    o_q.delete();
    stl_n = 0;
    rdy_n = 0;
    n = 0;
    u_iit_decode_model.push(a);
    u_iit_decode_model.push(b);
    while (o_q.size() < 2 && n < 40) begin
      @(negedge core_clk_i);
      n++;
    end
    if (o_q.size() < 2) begin
      checks_done++;
      mismatches++;
      $display("unexpected at %0t: pair not issued", $time);
    end else begin
      check(4'(t_q[1] - t_q[0]), gap, "issue distance");
      check(o_q[0], occ_a, "first occupancy");
      check(o_q[1], occ_b, "second occupancy");
    end
    repeat (12) @(negedge core_clk_i);
    // Stall covers the wait before the second issue and both busy tails.
    if (o_q.size() == 2) begin
      es = occ_b - 1 + ((u_iit_decode_model.idle_gap == 0) ? gap - 1 : occ_a - 1);
      check(4'(rdy_n), 4'h2, "ready pulses");
      check(4'(stl_n), 4'(es), "stall cycles");
    end
  endtask : pair

  // Prints the counts and the verdict, then stops.
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_of_test

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_latency();
    pair(mk(iit_pkg::OP_LOAD, iit_pkg::SH_NONE, 1, 2, 0, 0),
         mk(iit_pkg::OP_ALU, iit_pkg::SH_NONE, 6, 5, 4, 0), 1, 1, 1);
    pair(mk(iit_pkg::OP_ALU, iit_pkg::SH_NONE, 1, 2, 3, 0),
         mk(iit_pkg::OP_ALU, iit_pkg::SH_NONE, 9, 6, 1, 0), 1, 1, 1);
    pair(mk(iit_pkg::OP_LOAD, iit_pkg::SH_NONE, 1, 2, 0, 0),
         mk(iit_pkg::OP_ALU, iit_pkg::SH_NONE, 6, 5, 1, 0), 3, 1, 1);
    pair(mk(iit_pkg::OP_ALU, iit_pkg::SH_NONE, 2, 5, 6, 0),
         mk(iit_pkg::OP_LOAD, iit_pkg::SH_NONE, 1, 2, 0, 0), 2, 1, 1);
    pair(mk(iit_pkg::OP_LOAD, iit_pkg::SH_NONE, 1, 2, 0, 0),
         mk(iit_pkg::OP_LOAD, iit_pkg::SH_NONE, 5, 1, 0, 0), 4, 1, 1);
    pair(mk(iit_pkg::OP_ALU, iit_pkg::SH_NONE, 1, 2, 3, 0),
         mk(iit_pkg::OP_ALU, iit_pkg::SH_IMM, 4, 5, 1, 0), 2, 1, 1);
    pair(mk(iit_pkg::OP_ALU, iit_pkg::SH_NONE, 1, 2, 3, 0),
         mk(iit_pkg::OP_ALU, iit_pkg::SH_IMM, 4, 1, 9, 0), 1, 1, 1);
    pair(mk(iit_pkg::OP_ALU, iit_pkg::SH_NONE, 1, 2, 3, 0),
         mk(iit_pkg::OP_ALU, iit_pkg::SH_REG, 4, 2, 4, 1), 2, 1, 2);
    pair(mk(iit_pkg::OP_LOAD, iit_pkg::SH_NONE, 1, 2, 0, 0),
         mk(iit_pkg::OP_ALU, iit_pkg::SH_REG, 3, 1, 4, 5), 2, 1, 2);
    pair(mk(iit_pkg::OP_ALU, iit_pkg::SH_REG, 1, 2, 3, 4),
         mk(iit_pkg::OP_ALU, iit_pkg::SH_NONE, 5, 6, 1, 0), 2, 2, 1);
    $display("latency test done");
  endtask : t_latency

  // Program counter destinations, each followed by an independent operation.
  task automatic t_pc_dest();
    iit_pkg::iit_shift_type sh_t[8] = '{iit_pkg::SH_NONE, iit_pkg::SH_NONE, iit_pkg::SH_NONE,
        iit_pkg::SH_IMM, iit_pkg::SH_REG, iit_pkg::SH_NONE, iit_pkg::SH_IMM, iit_pkg::SH_REG};
    logic [3:0]             exp_t[8] = '{4'h4, 4'h7, 4'h5, 4'h6, 4'h7, 4'h7, 4'h7, 4'h8};
    iit_pkg::iit_instr_type x;
    for (int i = 0; i < 8; i++) begin
      x = mk(i < 5 ? iit_pkg::OP_MOV : iit_pkg::OP_ALU, sh_t[i], iit_pkg::PC_REG,
             i < 5 ? 4'h0 : 4'h2, i < 2 ? iit_pkg::LR_REG : 4'h3, 4'h4);
      x.ret_hit = (i == 0);
      pair(x, mk(iit_pkg::OP_ALU, iit_pkg::SH_NONE, 0, 0, 0, 0), exp_t[i], exp_t[i], 1);
    end
    $display("program counter test done");
  endtask : t_pc_dest

  // Condition failing and passing after a flag setter.
  task automatic t_cond();
    iit_pkg::iit_instr_type fs;
    iit_pkg::iit_instr_type m;
    fs = mk(iit_pkg::OP_ALU, iit_pkg::SH_NONE, 0, 2, 3, 0);
    fs.sets_flags = 1'b1;
    m = mk(iit_pkg::OP_MULTI, iit_pkg::SH_NONE, 7, 0, 0, 0);
    m.multi_cycles = 4'h6;
    pair(mk(iit_pkg::OP_ALU, iit_pkg::SH_NONE, 0, 0, 0, 0), m, 1, 1, 6);
    pair(fs, cnd(m, 4'h0, 1'b0), 1, 1, 5);
    u_iit_decode_model.idle_gap = 2;
    pair(fs, cnd(m, 4'h0, 1'b0), 3, 1, 3);
    u_iit_decode_model.idle_gap = 0;
    m.multi_cycles = 4'h4;
    pair(fs, cnd(m, 4'h0, 1'b0), 1, 1, 4);
    m.multi_cycles = 4'h2;
    pair(fs, cnd(m, 4'h0, 1'b0), 1, 1, 2);
    pair(fs, cnd(mk(iit_pkg::OP_ALU, iit_pkg::SH_REG, 4, 5, 6, 7), 4'h0, 1'b0), 1, 1, 2);
    pair(fs, cnd(mk(iit_pkg::OP_ALU, iit_pkg::SH_NONE, 4, 5, 6, 0), 4'h0, 1'b0), 1, 1, 1);
    pair(fs, cnd(mk(iit_pkg::OP_ALU, iit_pkg::SH_REG, iit_pkg::PC_REG, 5, 6, 7), 4'h0, 1'b0),
         1, 1, 2);
    m = mk(iit_pkg::OP_MOV, iit_pkg::SH_NONE, iit_pkg::PC_REG, 0, 3, 0);
    pair(fs, cnd(m, 4'h0, 1'b1), 1, 1, 7);
    u_iit_decode_model.idle_gap = 1;
    pair(fs, cnd(m, 4'h0, 1'b1), 2, 1, 6);
    u_iit_decode_model.idle_gap = 0;
    $display("condition test done");
  endtask : t_cond

  // Opposite-condition writers and store of one register.
  task automatic t_opposite();
    pair(cnd(mk(iit_pkg::OP_ALU, iit_pkg::SH_NONE, 1, 5, 6, 0), 4'h1, 1'b1),
         cnd(mk(iit_pkg::OP_LOAD, iit_pkg::SH_NONE, 1, 8, 0, 0), 4'h0, 1'b0), 1, 1, 1);
    pair(cnd(mk(iit_pkg::OP_LOAD, iit_pkg::SH_NONE, 1, 8, 0, 0), 4'h0, 1'b1),
         cnd(mk(iit_pkg::OP_ALU, iit_pkg::SH_NONE, 1, 5, 6, 0), 4'h1, 1'b0), 1, 1, 1);
    pair(cnd(mk(iit_pkg::OP_LOAD, iit_pkg::SH_NONE, 1, 5, 0, 0), 4'h1, 1'b1),
         cnd(mk(iit_pkg::OP_STORE, iit_pkg::SH_NONE, 1, 8, 1, 0), 4'h0, 1'b0), 1, 1, 1);
    pair(mk(iit_pkg::OP_LOAD, iit_pkg::SH_NONE, 1, 8, 0, 0),
         mk(iit_pkg::OP_ALU, iit_pkg::SH_NONE, 1, 5, 6, 0), 2, 1, 1);
    $display("opposite condition test done");
  endtask : t_opposite

  // Main sequence: reset for ten cycles, then every scenario in turn.
  initial begin
    core_clk_i = 1'b0;
    rst_i = 1'b1;
    mismatches = 0;
    checks_done = 0;
    cyc = 0;
    pend = 1'b0;
    repeat (10) @(negedge core_clk_i);
    check(flag_gap_cycles, 4'hf, "gap after reset");
    check(occupy_cycles, 4'h0, "occupancy after reset");
    rst_i = 1'b0;
    repeat (2) @(negedge core_clk_i);
    $display("reset test done");
    t_latency();
    t_pc_dest();
    t_cond();
    t_opposite();
    end_of_test();
  end
endmodule : issue_interlock_timing_tb
`default_nettype wire
